// ---- hw/mau_top.sv ----
// Multiply, divide and multiply accumulate datapath with its result pair.
// Assumes decode presents one request per cycle, synchronous to clk_i,
// and that the register file takes the write port one cycle later.
//
// Functional notes
// - Every multiply or divide result except multiply to general register lands in the high and low result pair, never in a general register.
// - A move from high or move from low copies that result word into the chosen general register.
// - Multiply to general register writes the low product word straight into the register file.
// - Multiply to general register may target any general register index.
// - Multiply add adds the product to the current pair and keeps the sum in the pair.
// - Multiply subtract takes the product away from the pair and keeps the difference there.
`timescale 1ns/1ps
`include "mau_map.svh"

module mau_top #(
  parameter int DATA_W = `MAU_DATA_W
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        req_valid_i,
  input  wire mau_pkg::mau_req_s           req_i,
  output logic                             wb_valid_o,
  output mau_pkg::mau_wb_s                 wb_o,
  output logic [`MAU_DATA_W-1:0]           product_high_word_o,
  output logic [`MAU_DATA_W-1:0]           product_low_word_o
);

  // The struct widths are fixed by the header, so the width cannot move.
  if (DATA_W != `MAU_DATA_W) begin : g_width_check
    $error("mau_top: DATA_W must equal the header data width");
  end

  // Product of two words, sign or zero extended to the full product width.
  function automatic logic [`MAU_PROD_W-1:0] mau_product(
    input logic [`MAU_DATA_W-1:0] a,
    input logic [`MAU_DATA_W-1:0] b,
    input logic                   sgn
  );
    logic [`MAU_PROD_W-1:0] ae;
    logic [`MAU_PROD_W-1:0] be;
    ae = {{`MAU_DATA_W{sgn & a[`MAU_DATA_W-1]}}, a};
    be = {{`MAU_DATA_W{sgn & b[`MAU_DATA_W-1]}}, b};
    return ae * be;
  endfunction

  logic                         rst_meta_ff;
  logic                         rst_n_ff;
  logic [`MAU_DATA_W-1:0]       high_ff;
  logic [`MAU_DATA_W-1:0]       low_ff;
  logic                         wb_valid_ff;
  mau_pkg::mau_wb_s             wb_ff;
  logic [`MAU_PROD_W-1:0]       prod;
  logic [`MAU_PROD_W-1:0]       pair;
  logic [`MAU_DATA_W-1:0]       quot;
  logic [`MAU_DATA_W-1:0]       rem;
  logic [`MAU_DATA_W:0]         div_a;
  logic [`MAU_DATA_W:0]         div_b;
  logic [`MAU_DATA_W:0]         div_q;
  logic [`MAU_DATA_W:0]         div_r;
  logic                         div_zero;

  // Reset is asserted at once but released through two flops.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Shared product and the current pair as one 64-bit value.
  assign prod = mau_product(req_i.a, req_i.b, req_i.sgn);
  assign pair = {high_ff, low_ff};

  // Divide in one cycle on 33-bit values, so the most negative signed
  // dividend over minus one cannot overflow before truncation.
  always_comb begin
    div_a    = {req_i.sgn & req_i.a[`MAU_DATA_W-1], req_i.a};
    div_b    = {req_i.sgn & req_i.b[`MAU_DATA_W-1], req_i.b};
    div_zero = (req_i.b == '0);
    div_q    = '0;
    div_r    = '0;
    if (!div_zero) begin
      div_q = $unsigned($signed(div_a) / $signed(div_b));
      div_r = $unsigned($signed(div_a) % $signed(div_b));
    end
    // A zero divisor gives all ones and leaves the dividend as remainder.
    quot = div_zero ? '1 : div_q[`MAU_DATA_W-1:0];
    rem  = div_zero ? req_i.a : div_r[`MAU_DATA_W-1:0];
  end

  // The result pair; moves and the register-file multiply leave it alone.
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      high_ff <= `MAU_HIGH_RST;
      low_ff  <= `MAU_LOW_RST;
    end else if (req_valid_i) begin
      case (req_i.op)
        mau_pkg::MAU_OP_MULT: begin
          {high_ff, low_ff} <= prod;
        end
        mau_pkg::MAU_OP_DIV: begin
          high_ff <= rem;
          low_ff  <= quot;
        end
        mau_pkg::MAU_OP_MULTIPLY_ADD: begin
          {high_ff, low_ff} <= pair + prod;
        end
        mau_pkg::MAU_OP_MULTIPLY_SUBTRACT: begin
          {high_ff, low_ff} <= pair - prod;
        end
        default: begin
          high_ff <= high_ff;
          low_ff  <= low_ff;
        end
      endcase
    end
  end

  // Register-file write port; one cycle after the request is taken.
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wb_valid_ff <= 1'b0;
      wb_ff       <= '0;
    end else begin
      wb_valid_ff <= 1'b0;
      wb_ff.dest  <= req_i.dest;
      wb_ff.data  <= `MAU_WB_RST;
      if (req_valid_i) begin
        case (req_i.op)
          mau_pkg::MAU_OP_MULTIPLY_TO_GPR: begin
            wb_valid_ff <= 1'b1;
            wb_ff.data  <= prod[`MAU_DATA_W-1:0];
          end
          mau_pkg::MAU_OP_MOVE_FROM_HIGH: begin
            wb_valid_ff <= 1'b1;
            wb_ff.data  <= high_ff;
          end
          mau_pkg::MAU_OP_MOVE_FROM_LOW: begin
            wb_valid_ff <= 1'b1;
            wb_ff.data  <= low_ff;
          end
          default: begin
            wb_valid_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign wb_valid_o          = wb_valid_ff;
  assign wb_o                = wb_ff;
  assign product_high_word_o = high_ff;
  assign product_low_word_o  = low_ff;

  // Checks of the datapath against its own inputs one cycle earlier.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_ff);

  logic is_mult;
  logic is_multiply_add;
  logic is_multiply_subtract;
  logic is_gpr;
  logic is_div;
  logic pair_keep;
  assign is_mult = req_valid_i && req_i.op == mau_pkg::MAU_OP_MULT;
  assign is_multiply_add = req_valid_i && req_i.op == mau_pkg::MAU_OP_MULTIPLY_ADD;
  assign is_multiply_subtract = req_valid_i
                   && req_i.op == mau_pkg::MAU_OP_MULTIPLY_SUBTRACT;
  assign is_gpr  = req_valid_i
                   && req_i.op == mau_pkg::MAU_OP_MULTIPLY_TO_GPR;
  assign is_div  = req_valid_i && req_i.op == mau_pkg::MAU_OP_DIV;
  assign pair_keep = !(is_mult || is_multiply_add || is_multiply_subtract || is_div);

  pair_on_div_a: assert property (
    is_div |=> low_ff == $past(quot) && high_ff == $past(rem)
      && !wb_valid_o)
    else $error("divide result not in the pair");

  move_high_a: assert property (
    req_valid_i && req_i.op == mau_pkg::MAU_OP_MOVE_FROM_HIGH
      |=> wb_valid_o && wb_o.data == $past(high_ff)
        && wb_o.dest == $past(req_i.dest))
    else $error("move from high wrote wrong data");

  move_low_a: assert property (
    req_valid_i && req_i.op == mau_pkg::MAU_OP_MOVE_FROM_LOW
      |=> wb_valid_o && wb_o.data == $past(low_ff))
    else $error("move from low wrote wrong data");

  gpr_mul_a: assert property (
    is_gpr |=> wb_valid_o && wb_o.data == $past(prod[31:0])
      && pair == $past(pair))
    else $error("register-file multiply wrong or touched pair");

  gpr_dest_a: assert property (
    is_gpr |=> wb_o.dest == $past(req_i.dest))
    else $error("register-file multiply lost its destination");

  multiply_add_sum_a: assert property (
    is_multiply_add |=> pair == $past(pair) + $past(prod))
    else $error("multiply add sum wrong");

  multiply_subtract_diff_a: assert property (
    is_multiply_subtract |=> pair == $past(pair) - $past(prod))
    else $error("multiply subtract difference wrong");

  mult_halves_a: assert property (
    is_mult |=> high_ff == $past(prod[63:32])
      && low_ff == $past(prod[31:0]) && !wb_valid_o)
    else $error("product halves misplaced");

  pair_hold_a: assert property (
    pair_keep |=> pair == $past(pair))
    else $error("pair changed without a multiply or divide");

  multiply_add_chain_c: cover property (is_multiply_add ##1 is_multiply_add ##1 is_multiply_subtract);
  mult_move_c: cover property (
    is_mult ##1 req_valid_i && req_i.op == mau_pkg::MAU_OP_MOVE_FROM_LOW);
  div_zero_c: cover property (is_div && div_zero);
  gpr_back_c: cover property (is_gpr ##1 is_gpr);

endmodule

// ---- include/mau_map.svh ----
// Constants of the multiply accumulate unit: widths and reset values.
// Assumes inclusion by its bare name from the package and the top module.
`ifndef MAU_MAP_SVH
`define MAU_MAP_SVH

`define MAU_DATA_W     32
`define MAU_PROD_W     64
`define MAU_REG_IDX_W  5
`define MAU_HIGH_RST   32'h0000_0000
`define MAU_LOW_RST    32'h0000_0000
`define MAU_WB_RST     32'h0000_0000

`endif

// ---- include/mau_pkg.sv ----
// Types shared by the multiply accumulate unit and its decode partner.
// Assumes the constant header is on the include path.
`include "mau_map.svh"

package mau_pkg;

  // Operations that the decode stage may hand to the unit.
  typedef enum logic [3:0] {
    MAU_OP_NONE,
    MAU_OP_MULT,
    MAU_OP_DIV,
    MAU_OP_MULTIPLY_ADD,
    MAU_OP_MULTIPLY_SUBTRACT,
    MAU_OP_MULTIPLY_TO_GPR,
    MAU_OP_MOVE_FROM_HIGH,
    MAU_OP_MOVE_FROM_LOW
  } mau_op_e;

  // One request from decode, with operands already read from the file.
  typedef struct packed {
    mau_op_e                    op;
    logic                       sgn;
    logic [`MAU_DATA_W-1:0]     a;
    logic [`MAU_DATA_W-1:0]     b;
    logic [`MAU_REG_IDX_W-1:0]  dest;
  } mau_req_s;

  // One write into the general register file.
  typedef struct packed {
    logic [`MAU_REG_IDX_W-1:0]  dest;
    logic [`MAU_DATA_W-1:0]     data;
  } mau_wb_s;

endpackage

// ---- sim/mau_rf_model.sv ----
// Register file model standing behind the unit's write port.
// Assumes writes arrive on the core clock, at most one per cycle.
`timescale 1ns/1ps
module mau_rf_model (
  input  wire logic             clk_i,
  input  wire logic             wb_valid_i,
  input  wire mau_pkg::mau_wb_s wb_i,
  input  wire logic [4:0]       rd_idx_i,
  output logic [31:0]           rd_data_o
);
  logic [31:0] regs_ff [32];
  // A write lands at the edge after the unit shows it, as the core would.
  always_ff @(posedge clk_i) begin
    if (wb_valid_i) begin
      regs_ff[wb_i.dest] <= wb_i.data;
    end
  end
  // Unwritten entries read unknown, so a missing write never passes.
  assign rd_data_o = regs_ff[rd_idx_i];
endmodule

// ---- sim/mau_top_bench.sv ----
// Self-checking bench for the multiply accumulate unit.
// Assumes the package and the register file model are compiled first.
`timescale 1ns/1ps
module mau_top_bench;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              req_valid = 1'b0;
  mau_pkg::mau_req_s req = '0;
  logic              wb_valid;
  mau_pkg::mau_wb_s  wb;
  logic [31:0]       hi;
  logic [31:0]       lo;
  logic [31:0]       rd_data;
  logic [4:0]        rd_idx = 5'h00;
  int                miscompares = 0;
  int                num_checks = 0;

  // Core clock, 10 ns period.
  always #5 clk_i = ~clk_i;

  mau_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
    .req_i(req), .wb_valid_o(wb_valid), .wb_o(wb),
    .product_high_word_o(hi), .product_low_word_o(lo));

  mau_rf_model rf (.clk_i(clk_i), .wb_valid_i(wb_valid), .wb_i(wb),
    .rd_idx_i(rd_idx), .rd_data_o(rd_data));

  // Compares one value and counts the result.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Presents one request at the next edge; held until the next call.
  task automatic drv(input mau_pkg::mau_op_e op, input logic s,
                     input logic [31:0] a, input logic [31:0] b,
                     input logic [4:0] d);
    @(posedge clk_i);
    req_valid <= 1'b1;
    req       <= '{op: op, sgn: s, a: a, b: b, dest: d};
  endtask

  // Drops the request for n edges, then lets the outputs settle.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      req_valid <= 1'b0;
    end
    #1;
  endtask

  // Reads one entry of the register file model.
  task automatic rf_chk(input logic [4:0] i, input logic [31:0] e);
    rd_idx = i;
    #1;
    chk({32'h0, rd_data}, {32'h0, e});
  endtask

  // Signed and unsigned products and three divides land in the pair.
  task automatic t_mult;
    drv(mau_pkg::MAU_OP_MULT, 1'b1, -32'sd3, 32'h7, 5'h00);
    idle(1);
    chk({hi, lo}, 64'hFFFF_FFFF_FFFF_FFEB);
    drv(mau_pkg::MAU_OP_MULT, 1'b0, 32'hFFFF_FFFF, 32'h2, 5'h00);
    idle(1);
    chk({hi, lo}, 64'h0000_0001_FFFF_FFFE);
    drv(mau_pkg::MAU_OP_DIV, 1'b0, 32'h64, 32'h7, 5'h00);
    idle(1);
    chk({hi, lo}, 64'h0000_0002_0000_000E);
    chk({63'h0, wb_valid}, 64'h0);
    // Signed divide truncates toward zero; remainder keeps dividend sign.
    drv(mau_pkg::MAU_OP_DIV, 1'b1, -32'sd7, 32'h2, 5'h00);
    idle(1);
    chk({hi, lo}, 64'hFFFF_FFFF_FFFF_FFFD);
    // A zero divisor gives all ones and keeps the dividend as remainder.
    drv(mau_pkg::MAU_OP_DIV, 1'b0, 32'h64, 32'h0, 5'h00);
    idle(1);
    chk({hi, lo}, 64'h0000_0064_FFFF_FFFF);
    $display("t_mult done");
  endtask

  // Moves issued right behind a multiply must see the new pair.
  task automatic t_move;
    drv(mau_pkg::MAU_OP_MULT, 1'b0, 32'h1234_5678, 32'h10, 5'h00);
    drv(mau_pkg::MAU_OP_MOVE_FROM_LOW, 1'b0, 32'h0, 32'h0, 5'h05);
    drv(mau_pkg::MAU_OP_MOVE_FROM_HIGH, 1'b0, 32'h0, 32'h0, 5'h06);
    idle(3);
    rf_chk(5'h05, 32'h2345_6780);
    rf_chk(5'h06, 32'h0000_0001);
    $display("t_move done");
  endtask

  // Multiply to register writes low word to several targets, pair kept.
  task automatic t_gpr;
    logic [4:0] d;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 5'h01 : ((i == 1) ? 5'h11 : 5'h1F);
      drv(mau_pkg::MAU_OP_MULTIPLY_TO_GPR, 1'b0, {27'h0, d}, 32'h3, d);
      idle(1);
      chk({31'h0, wb_valid, wb.data},
          {31'h0, 1'b1, ({27'h0, d} * 32'h3)});
      idle(1);
      chk({63'h0, wb_valid}, 64'h0);
      rf_chk(d, {27'h0, d} * 3);
    end
    chk({hi, lo}, 64'h0000_0001_2345_6780);
    $display("t_gpr done");
  endtask

  // Accumulate onto a fresh pair, then subtract a signed product.
  task automatic t_acc;
    drv(mau_pkg::MAU_OP_MULT, 1'b0, 32'hA, 32'hA, 5'h00);
    drv(mau_pkg::MAU_OP_MULTIPLY_ADD, 1'b0, 32'h1000_0000, 32'h20, 5'h00);
    idle(1);
    chk({hi, lo}, 64'h0000_0002_0000_0064);
    drv(mau_pkg::MAU_OP_MULTIPLY_SUBTRACT, 1'b1, -32'sd1, 32'h5, 5'h00);
    idle(1);
    chk({hi, lo}, 64'h0000_0002_0000_0069);
    $display("t_acc done");
  endtask

  // Reset in mid-run clears the pair at once; work resumes after release.
  task automatic t_reset;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    idle(2);
    chk({hi, lo}, 64'h0);
    chk({63'h0, wb_valid}, 64'h0);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(3);
    drv(mau_pkg::MAU_OP_MULT, 1'b0, 32'h2, 32'h3, 5'h00);
    idle(1);
    chk({hi, lo}, 64'h0000_0000_0000_0006);
    $display("t_reset done");
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset for 20 cycles, three quiet edges, then the scenarios.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(3);
    t_mult;
    t_move;
    t_gpr;
    t_acc;
    t_reset;
    end_of_test;
  end

  // The tests need about 60 cycles; a hang is cut off well beyond that.
  initial begin
    #20000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule
